// [core/fsp_top.sv]
// Flash security, backdoor key and block protection control with its registers
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module fsp_top
  import fsp_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           reset,
  input  wire fsp_bus_req_s   bus_req,
  output logic [7:0]          bus_rdata,
  input  wire logic [7:0]     stored_option_byte,
  input  wire logic [7:0]     stored_protection_byte,
  input  wire logic [63:0]    stored_backdoor_key,
  output fsp_flash_cmd_s      flash_cmd,
  input  wire logic           flash_done,
  input  wire logic           flash_blank,
  output logic                secured,
  output logic                dbg_mem_allow,
  output logic                vector_redirect_en,
  output logic                irq
);
  logic [7:0]           option_shadow_reg_r;
  logic [7:0]           flash_config_reg_r;
  logic [7:0]           protection_shadow_reg_r;
  logic [7:0]           flash_status_reg_r;
  logic [7:0]           flash_status_reg_nxt;
  logic [6:0]           cmd_code_r;
  logic [15:0]          lat_addr_r;
  logic [7:0]           lat_data_r;
  logic                 lat_valid_r;
  logic                 blank_run_r;
  logic [FSP_IRQ_W-1:0] irq_stat_r;
  logic [FSP_IRQ_W-1:0] irq_mask_r;
  logic [FSP_IRQ_W-1:0] irq_evt;
  fsp_cmd_state_e       state_r;
  fsp_flash_cmd_s       flash_cmd_r;
  logic [7:0]           rdata_r;
  logic                 key_match;
  logic                 prot_viol;

  // Decode
  wire wr         = bus_req.wr;
  wire usr_wr     = wr & ~bus_req.dbg;
  wire wr_opt     = wr & (bus_req.addr == FSP_OPT_ADDR);
  wire wr_cfg     = wr & (bus_req.addr == FSP_CFG_ADDR);
  wire wr_prot    = wr & (bus_req.addr == FSP_PROT_ADDR) & bus_req.dbg;
  wire wr_stat    = wr & (bus_req.addr == FSP_STAT_ADDR);
  wire wr_cmd     = wr & (bus_req.addr == FSP_CMD_ADDR);
  wire wr_ist     = wr & (bus_req.addr == FSP_IST_ADDR);
  wire wr_imsk    = wr & (bus_req.addr == FSP_IMSK_ADDR);
  wire key_acc    = flash_config_reg_r[FSP_KEY_ACCESS_BIT];
  wire backdoor_enable = option_shadow_reg_r[FSP_BACKDOOR_EN_BIT];
  wire in_key     = fsp_in_key(bus_req.addr);
  wire in_flash   = bus_req.addr >= FSP_FLASH_LO;
  // Key range is steered by the key access bit; debug writes never compare
  wire key_wr     = usr_wr & in_key & key_acc & backdoor_enable;
  wire arr_wr     = wr & in_flash & ~(in_key & key_acc);
  wire idle       = (state_r == FSP_IDLE);
  wire cbef       = flash_status_reg_r[FSP_ST_CBEF];
  wire launch     = wr_stat & bus_req.wdata[FSP_ST_CBEF] & cbef & idle;
  wire cmd_legal  = (cmd_code_r == FSP_CMD_BLANK) || (cmd_code_r == FSP_CMD_PROG) ||
                    (cmd_code_r == FSP_CMD_BURST) || (cmd_code_r == FSP_CMD_PAGE) ||
                    (cmd_code_r == FSP_CMD_MASS);
  wire acc_err    = launch & (~lat_valid_r | ~cmd_legal) | (arr_wr & lat_valid_r);
  wire pv_hit     = launch & lat_valid_r & cmd_legal & prot_viol;
  wire go         = launch & lat_valid_r & cmd_legal & ~prot_viol;
  wire blank_ok   = flash_done & blank_run_r & flash_blank;
  wire unlock     = key_match | blank_ok;

  fsp_key_cmp #(
    .KEY_BYTES (8)
  ) u_key (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .key_wr    (key_wr),
    .key_idx   (bus_req.addr[2:0]),
    .key_data  (bus_req.wdata),
    .key_ref   (stored_backdoor_key),
    .key_match (key_match),
    .key_fail  ()
  );

  fsp_prot_chk u_prot (
    .prot_reg  (protection_shadow_reg_r),
    .cmd       (cmd_code_r),
    .addr      (lat_addr_r),
    .violation (prot_viol)
  );

  // Option shadow: loaded while reset is held, later changed only by unlock setting bits 1:0, ignores all bus writes to it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      option_shadow_reg_r <= stored_option_byte & FSP_OPT_MASK;
    end else if (unlock) begin
      option_shadow_reg_r[1:0] <= FSP_UNSECURED_CODE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      protection_shadow_reg_r <= stored_protection_byte & FSP_PROT_MASK;
    end else if (wr_prot) begin
      protection_shadow_reg_r <= bus_req.wdata & FSP_PROT_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flash_config_reg_r <= 8'h00;
    end else if (wr_cfg) begin
      flash_config_reg_r <= bus_req.wdata & FSP_CFG_MASK;
    end
  end

  // Status next value: hardware sets win over write-one clears
  always_comb begin
    flash_status_reg_nxt = flash_status_reg_r;
    if (wr_stat && bus_req.wdata[FSP_ST_PVIOL]) begin
      flash_status_reg_nxt[FSP_ST_PVIOL] = 1'b0;
    end
    if (wr_stat && bus_req.wdata[FSP_ST_ACCERR]) begin
      flash_status_reg_nxt[FSP_ST_ACCERR] = 1'b0;
    end
    if (pv_hit) begin
      flash_status_reg_nxt[FSP_ST_PVIOL] = 1'b1;
    end
    if (acc_err) begin
      flash_status_reg_nxt[FSP_ST_ACCERR] = 1'b1;
    end
    if (go) begin
      flash_status_reg_nxt[FSP_ST_CBEF]  = 1'b0;
      flash_status_reg_nxt[FSP_ST_CCF]   = 1'b0;
      flash_status_reg_nxt[FSP_ST_BLANK] = 1'b0;
    end
    if (flash_done && !idle) begin
      flash_status_reg_nxt[FSP_ST_CBEF]  = 1'b1;
      flash_status_reg_nxt[FSP_ST_CCF]   = 1'b1;
      flash_status_reg_nxt[FSP_ST_BLANK] = blank_ok;
    end
    flash_status_reg_nxt[3] = 1'b0;
    flash_status_reg_nxt[1] = 1'b0;
    flash_status_reg_nxt[0] = 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flash_status_reg_r <= FSP_STAT_RST;
    end else begin
      flash_status_reg_r <= flash_status_reg_nxt;
    end
  end

  // Command capture: one array write latches address and data before launch
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd_code_r  <= 7'h00;
      lat_addr_r  <= 16'h0000;
      lat_data_r  <= 8'h00;
      lat_valid_r <= 1'b0;
    end else begin
      if (wr_cmd && idle) begin
        cmd_code_r <= bus_req.wdata[6:0];
      end
      if (arr_wr && !lat_valid_r && idle) begin
        lat_addr_r  <= bus_req.addr;
        lat_data_r  <= bus_req.wdata;
        lat_valid_r <= 1'b1;
      end else if (launch) begin
        lat_valid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r     <= FSP_IDLE;
      blank_run_r <= 1'b0;
    end else begin
      unique case (state_r)
        FSP_IDLE: begin
          if (go) begin
            state_r     <= FSP_BUSY;
            blank_run_r <= (cmd_code_r == FSP_CMD_BLANK);
          end
        end
        FSP_BUSY: begin
          if (flash_done) begin
            state_r     <= FSP_IDLE;
            blank_run_r <= 1'b0;
          end
        end
        default: begin
          state_r <= FSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flash_cmd_r <= '0;
    end else begin
      flash_cmd_r.start <= go;
      if (go) begin
        flash_cmd_r.cmd  <= cmd_code_r;
        flash_cmd_r.addr <= lat_addr_r;
        flash_cmd_r.data <= lat_data_r;
      end
    end
  end
  assign flash_cmd = flash_cmd_r;

  // Interrupt status
  always_comb begin
    irq_evt                = '0;
    irq_evt[FSP_IRQ_PVIOL] = pv_hit;
    irq_evt[FSP_IRQ_ACC]   = acc_err;
    irq_evt[FSP_IRQ_DONE]  = flash_done & ~idle;
    irq_evt[FSP_IRQ_OPEN]  = unlock;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~({FSP_IRQ_W{wr_ist}} & bus_req.wdata[FSP_IRQ_W-1:0]))
                    | irq_evt;
      if (wr_imsk) begin
        irq_mask_r <= bus_req.wdata[FSP_IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read port: data stand in the cycle after the strobe only
  logic [7:0] rd_mux;
  always_comb begin
    unique case (bus_req.addr)
      FSP_OPT_ADDR:  rd_mux = option_shadow_reg_r;
      FSP_CFG_ADDR:  rd_mux = flash_config_reg_r;
      FSP_PROT_ADDR: rd_mux = protection_shadow_reg_r;
      FSP_STAT_ADDR: rd_mux = flash_status_reg_r;
      FSP_IST_ADDR:  rd_mux = {4'h0, irq_stat_r};
      FSP_IMSK_ADDR: rd_mux = {4'h0, irq_mask_r};
      default:       rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= bus_req.rd ? rd_mux : 8'h00;
    end
  end
  assign bus_rdata = rdata_r;

  assign secured            = option_shadow_reg_r[1:0] != FSP_UNSECURED_CODE;
  assign dbg_mem_allow      = ~secured;
  assign vector_redirect_en = ~option_shadow_reg_r[FSP_NORED_BIT];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_opt_hold;
    !unlock |=> option_shadow_reg_r == $past(option_shadow_reg_r);
  endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("option shadow changed");

  property p_opt_zero;
    option_shadow_reg_r[5:2] == 4'h0;
  endproperty
  a_opt_zero: assert property (p_opt_zero) else $error("option bits 5..2 set");

  property p_noken;
    !backdoor_enable |-> !key_match;
  endproperty
  a_noken: assert property (p_noken) else $error("key write without enable");

  property p_unlock;
    key_match |=> !secured ##1 !secured;
  endproperty
  a_unlock: assert property (p_unlock) else $error("match did not unsecure");

  property p_dbg_key;
    bus_req.dbg |-> !key_match;
  endproperty
  a_dbg_key: assert property (p_dbg_key) else $error("debug key write taken");

  property p_dbg_block;
    (option_shadow_reg_r[1:0] != FSP_UNSECURED_CODE) |-> !dbg_mem_allow;
  endproperty
  a_dbg_block: assert property (p_dbg_block) else $error("debug allowed while secured");

  property p_prot_usr;
    (wr && !bus_req.dbg) |=> $stable(protection_shadow_reg_r);
  endproperty
  a_prot_usr: assert property (p_prot_usr) else $error("user write hit protection");

  property p_pviol;
    pv_hit |=> flash_status_reg_r[FSP_ST_PVIOL] && !flash_cmd_r.start && idle;
  endproperty
  a_pviol: assert property (p_pviol) else $error("violation not flagged");

  property p_stat_zero;
    {flash_status_reg_r[3], flash_status_reg_r[1:0]} == 3'b000;
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("reserved status bit set");

  property p_cfg;
    wr_cfg |=> flash_config_reg_r == (($past(bus_req.wdata)) & FSP_CFG_MASK);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config write wrong");
endmodule : fsp_top

// [core/fsp_pkg.sv]
// Constants, types and helpers shared by the flash security/protection block
package fsp_pkg;
  localparam logic [15:0] FSP_OPT_ADDR  = 16'h1821;
  localparam logic [15:0] FSP_CFG_ADDR  = 16'h1823;
  localparam logic [15:0] FSP_PROT_ADDR = 16'h1824;
  localparam logic [15:0] FSP_STAT_ADDR = 16'h1825;
  localparam logic [15:0] FSP_CMD_ADDR  = 16'h1826;
  localparam logic [15:0] FSP_IST_ADDR  = 16'h1828;
  localparam logic [15:0] FSP_IMSK_ADDR = 16'h1829;
  localparam logic [15:0] FSP_KEY_LO    = 16'hFFB0;
  localparam logic [15:0] FSP_KEY_HI    = 16'hFFB7;
  localparam logic [15:0] FSP_FLASH_LO  = 16'h8000;
  localparam logic [7:0]  FSP_OPT_MASK  = 8'hC3;
  localparam logic [7:0]  FSP_PROT_MASK = 8'hFF;
  localparam logic [7:0]  FSP_CFG_MASK  = 8'h20;
  localparam logic [7:0]  FSP_STAT_RST  = 8'hC0;
  localparam int          FSP_BACKDOOR_EN_BIT = 7;
  localparam int          FSP_NORED_BIT = 6;
  localparam int          FSP_KEY_ACCESS_BIT = 5;
  localparam int          FSP_PDIS_BIT  = 0;
  localparam int          FSP_ST_CBEF   = 7;
  localparam int          FSP_ST_CCF    = 6;
  localparam int          FSP_ST_PVIOL  = 5;
  localparam int          FSP_ST_ACCERR = 4;
  localparam int          FSP_ST_BLANK  = 2;
  localparam logic [1:0]  FSP_UNSECURED_CODE = 2'b10;
  localparam logic [6:0]  FSP_CMD_BLANK = 7'h05;
  localparam logic [6:0]  FSP_CMD_PROG  = 7'h20;
  localparam logic [6:0]  FSP_CMD_BURST = 7'h25;
  localparam logic [6:0]  FSP_CMD_PAGE  = 7'h40;
  localparam logic [6:0]  FSP_CMD_MASS  = 7'h41;
  localparam int          FSP_IRQ_W     = 4;
  localparam int          FSP_IRQ_PVIOL = 0;
  localparam int          FSP_IRQ_ACC   = 1;
  localparam int          FSP_IRQ_DONE  = 2;
  localparam int          FSP_IRQ_OPEN  = 3;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        dbg;
  } fsp_bus_req_s;

  typedef struct packed {
    logic        start;
    logic [6:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  data;
  } fsp_flash_cmd_s;

  typedef enum logic [1:0] {
    FSP_IDLE = 2'b01,
    FSP_BUSY = 2'b10
  } fsp_cmd_state_e;

  function automatic logic fsp_in_key(input logic [15:0] a);
    return (a >= FSP_KEY_LO) && (a <= FSP_KEY_HI);
  endfunction : fsp_in_key
endpackage : fsp_pkg

// [core/fsp_key_cmp.sv]
// Backdoor key comparator: checks key bytes written in ascending order
`timescale 1ns/1ps
module fsp_key_cmp
  import fsp_pkg::*;
#(
  parameter int KEY_BYTES = 8
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   key_wr,
  input  wire logic [2:0]             key_idx,
  input  wire logic [7:0]             key_data,
  input  wire logic [8*KEY_BYTES-1:0] key_ref,
  output logic                        key_match,
  output logic                        key_fail
);
  // Position index is three address bits wide, so only an 8-byte key fits
  if (KEY_BYTES != 8) begin : g_key_bytes_chk
    $error("fsp_key_cmp serves an 8-byte key only");
  end

  logic [2:0] exp_idx_r;
  logic       bad_r;
  wire        last    = (exp_idx_r == 3'(KEY_BYTES - 1));
  wire        byte_ok = (key_idx == exp_idx_r) && (key_data == key_ref[8*exp_idx_r +: 8]);
  wire        bad_nxt = bad_r | ~byte_ok;

  // A mismatch is remembered so the whole sequence fails, not only that byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      exp_idx_r <= 3'h0;
      bad_r     <= 1'b0;
    end else if (key_wr) begin
      exp_idx_r <= last ? 3'h0 : exp_idx_r + 3'h1;
      bad_r     <= last ? 1'b0 : bad_nxt;
    end
  end

  assign key_match = key_wr & last & ~bad_nxt;
  assign key_fail  = key_wr & last & bad_nxt;
endmodule : fsp_key_cmp

// [core/fsp_prot_chk.sv]
// Flash protection window check for program and erase commands
`timescale 1ns/1ps
module fsp_prot_chk
  import fsp_pkg::*;
(
  input  wire logic [7:0]  prot_reg,
  input  wire logic [6:0]  cmd,
  input  wire logic [15:0] addr,
  output logic             violation
);
  // Unprotected flash ends at the select field followed by all-ones page bits
  wire [15:0] unprot_end = {prot_reg[7:1], 9'h1FF};
  wire        prot_on    = ~prot_reg[FSP_PDIS_BIT];
  wire        is_change  = (cmd == FSP_CMD_PROG) || (cmd == FSP_CMD_BURST) ||
                           (cmd == FSP_CMD_PAGE);
  // Mass erase would wipe the protected block too, so any protection refuses it
  assign violation = prot_on &&
                     ((is_change && (addr > unprot_end)) || (cmd == FSP_CMD_MASS));
endmodule : fsp_prot_chk

// [bench/fsp_flash_array_model.sv]
// Behavioural flash array that answers launched commands after a settable delay
`timescale 1ns/1ps
module fsp_flash_array_model
  import fsp_pkg::*;
(
  input  wire logic           clk_sys,
  input  wire logic           reset,
  input  wire fsp_flash_cmd_s flash_cmd,
  input  wire logic [7:0]     done_delay,
  input  wire logic           array_blank,
  output logic                flash_done,
  output logic                flash_blank,
  output logic [7:0]          start_count
);
  logic [7:0] busy_cnt_r;
  logic       busy_r;
  logic       noise_r;

  // Blank result only means something beside done; elsewhere it wanders
  assign flash_blank = flash_done ? array_blank : noise_r;

  always_ff @(posedge clk_sys) begin
    noise_r    <= reset ? 1'b0 : ~noise_r;
    flash_done <= 1'b0;
    if (reset) begin
      busy_r      <= 1'b0;
      busy_cnt_r  <= 8'h00;
      start_count <= 8'h00;
    end else if (flash_cmd.start) begin
      busy_r      <= 1'b1;
      busy_cnt_r  <= done_delay;
      start_count <= start_count + 8'h01;
    end else if (busy_r) begin
      if (busy_cnt_r == 8'h00) begin
        busy_r     <= 1'b0;
        flash_done <= 1'b1;
      end else begin
        busy_cnt_r <= busy_cnt_r - 8'h01;
      end
    end
  end
endmodule : fsp_flash_array_model

// [bench/tb_flash_security_protection_options.sv]
// Self-checking bench for the flash security and protection block
`timescale 1ns/1ps
module tb_flash_security_protection_options
  import fsp_pkg::*;
;
  localparam logic [63:0] KEY = 64'h5A3C_96E1_0F7B_C824;
  logic           clk_sys;
  logic           reset;
  fsp_bus_req_s   req;
  logic [7:0]     bus_rdata;
  logic [7:0]     opt_b;
  logic [7:0]     prot_b;
  fsp_flash_cmd_s flash_cmd;
  logic           flash_done;
  logic           flash_blank;
  logic           secured;
  logic           dbg_mem_allow;
  logic           vector_redirect_en;
  logic           irq;
  logic [7:0]     done_delay;
  logic           array_blank;
  logic [7:0]     start_count;
  logic [7:0]     st;
  logic [7:0]     exp_starts;
  logic [6:0]     codes [4];
  int             n_errors;
  int             compares;

  fsp_top i_dut (.clk_sys(clk_sys), .reset(reset), .bus_req(req), .bus_rdata(bus_rdata),
    .stored_option_byte(opt_b), .stored_protection_byte(prot_b),
    .stored_backdoor_key(KEY), .flash_cmd(flash_cmd), .flash_done(flash_done),
    .flash_blank(flash_blank), .secured(secured), .dbg_mem_allow(dbg_mem_allow),
    .vector_redirect_en(vector_redirect_en), .irq(irq));

  fsp_flash_array_model i_array (.clk_sys(clk_sys), .reset(reset), .flash_cmd(flash_cmd),
    .done_delay(done_delay), .array_blank(array_blank), .flash_done(flash_done),
    .flash_blank(flash_blank), .start_count(start_count));

  always #5 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus_wr(input logic [15:0] a, input logic [7:0] d, input logic dbg = 1'b0);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, dbg: dbg};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    // Let the write settle so callers see its effect on outputs
    #1;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, dbg: 1'b0};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask : bus_rd

  task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] v;
    bus_rd(a, v);
    check(what, v, exp);
  endtask : rd_chk

  task automatic do_reset(input logic [7:0] o, input logic [7:0] p);
    @(posedge clk_sys);
    opt_b  <= o;
    prot_b <= p;
    reset  <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
  endtask : do_reset

  // Ascending key addresses; the comparator pairs address low bits with key position
  task automatic key_seq(input logic [63:0] k, input logic dbg);
    for (int i = 0; i < 8; i++) begin
      bus_wr(FSP_KEY_LO + 16'(i), k[8*i +: 8], dbg);
    end
    repeat (2) @(posedge clk_sys);
  endtask : key_seq

  // Latch, code, launch, then poll for completion under a bounded count
  task automatic flash_op(input logic [15:0] a, input logic [7:0] d, input logic [6:0] c);
    bus_wr(a, d);
    bus_wr(FSP_CMD_ADDR, {1'b0, c});
    bus_wr(FSP_STAT_ADDR, 8'h80);
    for (int i = 0; i < 40; i++) begin
      bus_rd(FSP_STAT_ADDR, st);
      if (st[FSP_ST_CCF] === 1'b1) break;
    end
  endtask : flash_op

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    clk_sys     = 1'b0;
    reset       = 1'b1;
    req         = '0;
    opt_b       = 8'h00;
    prot_b      = 8'h00;
    done_delay  = 8'd20;
    array_blank = 1'b0;
    n_errors    = 0;
    compares    = 0;
    codes       = '{FSP_CMD_PROG, FSP_CMD_BURST, FSP_CMD_PAGE, FSP_CMD_MASS};
    // Every security code, reserved option bits set to prove they read zero
    for (int s = 0; s < 4; s++) begin
      do_reset({1'b1, s[0], 4'hF, s[1:0]}, 8'h5A + 8'(s));
      rd_chk("option", FSP_OPT_ADDR, {1'b1, s[0], 4'h0, s[1:0]});
      rd_chk("protection", FSP_PROT_ADDR, 8'h5A + 8'(s));
      check("secured", {7'h00, secured}, {7'h00, s != 2});
      check("debug allow", {7'h00, dbg_mem_allow}, {7'h00, s == 2});
      check("redirect", {7'h00, vector_redirect_en}, {7'h00, ~s[0]});
    end
    $display("test decode done");

    do_reset(8'h81, 8'h5A);
    bus_wr(FSP_OPT_ADDR, 8'hFF);
    rd_chk("option write", FSP_OPT_ADDR, 8'h81);
    bus_wr(FSP_CFG_ADDR, 8'hFF);
    rd_chk("config set", FSP_CFG_ADDR, 8'h20);
    bus_wr(FSP_CFG_ADDR, 8'h00);
    rd_chk("config clear", FSP_CFG_ADDR, 8'h00);
    bus_wr(FSP_PROT_ADDR, 8'h00);
    rd_chk("prot user write", FSP_PROT_ADDR, 8'h5A);
    bus_wr(FSP_PROT_ADDR, 8'hC3, 1'b1);
    rd_chk("prot debug write", FSP_PROT_ADDR, 8'hC3);
    bus_wr(FSP_STAT_ADDR, 8'h0B);
    rd_chk("status reserved", FSP_STAT_ADDR, 8'hC0);
    // Read data must drop back to zero one cycle after it stood
    @(posedge clk_sys);
    #1 check("rdata one cycle", bus_rdata, 8'h00);
    rd_chk("unmapped", 16'h1822, 8'h00);
    $display("test registers done");

    do_reset(8'h81, 8'hFF);
    bus_wr(FSP_CFG_ADDR, 8'h20);
    key_seq(KEY, 1'b1);
    check("debug key", {7'h00, secured}, 8'h01);
    key_seq(KEY ^ 64'h0000_0000_FF00_0000, 1'b0);
    check("wrong key", {7'h00, secured}, 8'h01);
    key_seq(KEY, 1'b0);
    check("good key", {7'h00, secured}, 8'h00);
    rd_chk("option open", FSP_OPT_ADDR, 8'h82);
    bus_rd(FSP_IST_ADDR, st);
    check("open event", st & 8'h08, 8'h08);
    do_reset(8'h01, 8'hFF);
    bus_wr(FSP_CFG_ADDR, 8'h20);
    key_seq(KEY, 1'b0);
    check("key disabled", {7'h00, secured}, 8'h01);
    $display("test backdoor done");

    // Unprotected flash ends at 0x81FF with this select value
    do_reset(8'h81, 8'h80);
    flash_op(16'h81FF, 8'h55, FSP_CMD_PROG);
    check("edge prog status", st & 8'h74, 8'h40);
    check("edge prog start", start_count, 8'h01);
    check("cmd addr", flash_cmd.addr[7:0], 8'hFF);
    check("cmd data", flash_cmd.data, 8'h55);
    flash_op(16'h8200, 8'h66, FSP_CMD_PROG);
    check("viol flag", st & 8'h20, 8'h20);
    check("viol no start", start_count, 8'h01);
    // Done event of the first command is still pending beside the violation
    rd_chk("viol event", FSP_IST_ADDR, 8'h05);
    check("irq masked", {7'h00, irq}, 8'h00);
    bus_wr(FSP_IMSK_ADDR, 8'h01);
    check("irq on", {7'h00, irq}, 8'h01);
    bus_wr(FSP_STAT_ADDR, 8'h20);
    bus_rd(FSP_STAT_ADDR, st);
    check("viol clear", st & 8'h20, 8'h00);
    bus_wr(FSP_IST_ADDR, 8'h01);
    check("irq off", {7'h00, irq}, 8'h00);
    flash_op(16'h8000, 8'h00, FSP_CMD_MASS);
    check("mass viol", st & 8'h20, 8'h20);
    bus_wr(FSP_STAT_ADDR, 8'h20);
    bus_wr(FSP_PROT_ADDR, 8'h81, 1'b1);
    done_delay <= 8'd1;
    exp_starts = 8'h01;
    for (int k = 0; k < 4; k++) begin
      flash_op(16'h9000, 8'h3C, codes[k]);
      exp_starts++;
      check("open start", start_count, exp_starts);
      check("open cmd", {1'b0, flash_cmd.cmd}, {1'b0, codes[k]});
      check("open status", st & 8'h74, 8'h40);
    end
    // An unknown command code is refused with an access error and no start
    flash_op(16'h9000, 8'h00, 7'h7F);
    check("illegal code", st & 8'h30, 8'h10);
    check("illegal no start", start_count, exp_starts);
    bus_wr(FSP_STAT_ADDR, 8'h10);
    flash_op(16'hFFB3, 8'h11, FSP_CMD_PROG);
    check("key range cmd", flash_cmd.addr[7:0], 8'hB3);
    flash_op(16'h8000, 8'h00, FSP_CMD_BLANK);
    check("not blank", st & 8'h04, 8'h00);
    check("not blank sec", {7'h00, secured}, 8'h01);
    array_blank <= 1'b1;
    flash_op(16'h8000, 8'h00, FSP_CMD_BLANK);
    check("blank flag", st & 8'h04, 8'h04);
    check("blank open", {7'h00, secured}, 8'h00);
    $display("test flash commands done");
    report_and_stop();
  end
endmodule : tb_flash_security_protection_options
